// ---- rtl/exec_pkg.sv ----
package exec_pkg;

    localparam logic [15:0] OPC_DECIMAL_ADJUST = 16'h0007;
    localparam logic [5:0]  OPC_DECREMENT      = 6'h01;
    localparam logic [6:0]  OPC_COMPARE_LESS   = 7'h30;
    localparam logic [3:0]  BCD_LIMIT          = 4'h9;
    localparam logic [3:0]  BCD_CORRECTION     = 4'h6;
    localparam logic [7:0]  RESET_WORKING      = 8'h00;
    localparam logic [3:0]  RESET_BANK         = 4'h0;
    localparam logic [1:0]  SKIP_ONE_WORD      = 2'h1;
    localparam logic [1:0]  SKIP_TWO_WORD      = 2'h2;

    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic dcarry;
        logic carry;
    } status_t;

    localparam status_t RESET_STATUS = '{neg: 1'b0, ovf: 1'b0, zero: 1'b0, dcarry: 1'b0, carry: 1'b0};

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
        logic        write;
    } mem_req_t;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'b00,
        ST_IDLE1 = 2'b01,
        ST_IDLE2 = 2'b10
    } exec_state_t;

endpackage

// ---- rtl/bcd_adjust_decrement_skip_exec.sv ----
// Functional notes
// - Compare skip discards next word, one idle cycle, two if it is two-word.
// - Decimal adjust adds 6 to low nibble if above 9 or digit carry.
// - Decimal adjust adds 6 to high nibble if above 9 or carry.
// - Decimal adjust is one word, one cycle, opcode ends 0111, touches carry only.
// - Decrement subtracts one, updates five flags, destination bit picks W or register.
// - Bank bit zero addresses access bank; one uses bank select register.
// - Less compare skips only when register is unsigned smaller than W.
module bcd_adjust_decrement_skip_exec (
    input  wire logic             CLK,
    input  wire logic             RESET,
    input  wire logic             INSTR_VALID,
    input  wire logic [15:0]      INSTR,
    input  wire logic             NEXT_IS_TWO_WORD,
    input  wire logic [7:0]       REG_RDATA,
    input  wire logic             BANK_LOAD,
    input  wire logic [3:0]       BANK_VALUE,
    output logic [7:0]            WORKING,
    output exec_pkg::status_t     STATUS,
    output logic [3:0]            BANK,
    output exec_pkg::mem_req_t    MEM_WRITE,
    output logic                  DISCARD
);

    ////////////////////////////////////////////////////////////////////////////
    exec_pkg::exec_state_t state;
    exec_pkg::exec_state_t next_state;

    logic        active;
    logic        is_adjust;
    logic        is_decrement;
    logic        is_compare;
    logic [11:0] eff_addr;
    logic [7:0]  dec_result;
    logic [4:0]  low_adj;
    logic [4:0]  high_adj;
    logic [3:0]  high_in;
    logic [8:0]  dec_full;
    logic [4:0]  dec_low;
    logic        low_wrap;
    logic        dec_ovf;
    logic        dec_zero;

    ////////////////////////////////////////////////////////////////////////////
    // Each word offered in the execute slot is taken at the clock edge it is
    // offered on. Results come from flops one cycle later. Back to back words
    // are fine. The only stall is the one or two idle slots that a taken skip opens,
    // and the core ignores whatever the fetch side offers during them.

    // Opcode recognisers, so each decode line reads like the encoding it matches
    function automatic logic is_adjust_word(input logic [15:0] word);
        return word == exec_pkg::OPC_DECIMAL_ADJUST;
    endfunction

    function automatic logic is_decrement_word(input logic [15:0] word);
        return word[15:10] == exec_pkg::OPC_DECREMENT;
    endfunction

    function automatic logic is_compare_word(input logic [15:0] word);
        return word[15:9] == exec_pkg::OPC_COMPARE_LESS;
    endfunction

    // Destination bit of a byte word: zero sends the result to the working register
    function automatic logic to_register(input logic [15:0] word);
        return word[9];
    endfunction

    // Access bank: low half of bank 0 or high half of bank 15, so the top
    // of the file address simply repeats bit 7 of the short address
    function automatic logic [11:0] bank_address(input logic [15:0] word, input logic [3:0] bank);
        logic [11:0] addr;
        addr = {{4{word[7]}}, word[7:0]};
        if (word[8]) begin
            addr = {bank, word[7:0]};
        end
        return addr;
    endfunction

    // One BCD digit correction shared by both nibbles; bit 4 is the carry out
    function automatic logic [4:0] digit_fix(input logic [3:0] digit, input logic force_fix);
        logic [4:0] sum;
        sum = {1'b0, digit};
        if (digit > exec_pkg::BCD_LIMIT || force_fix) begin
            sum = sum + {1'b0, exec_pkg::BCD_CORRECTION};
        end
        return sum;
    endfunction

    // Idle cycles swallow the incoming word, so nothing executes then
    assign active       = INSTR_VALID && (state == exec_pkg::ST_EXEC);
    assign is_adjust    = active && is_adjust_word(INSTR);
    assign is_decrement = active && is_decrement_word(INSTR);
    assign is_compare   = active && is_compare_word(INSTR);

    assign eff_addr = bank_address(INSTR, BANK);

    ////////////////////////////////////////////////////////////////////////////
    // Decimal adjust: high nibble sees the low-nibble carry before its test.
    // The result is decimal only after adding two packed BCD values; any other
    // byte still gets a defined answer, just not a meaningful one.
    // A low-digit carry that wraps an F high digit to zero is a decimal overflow
    // as well, so it forces the high correction and the carry.
    assign low_adj  = digit_fix(WORKING[3:0], STATUS.dcarry);
    assign high_in  = WORKING[7:4] + {3'h0, low_adj[4]};
    assign low_wrap = low_adj[4] && (WORKING[7:4] == 4'hF);
    assign high_adj = digit_fix(high_in, STATUS.carry || low_wrap);

    // Decrement as add of 0xFF so carry means no borrow
    assign dec_full   = {1'b0, REG_RDATA} + 9'h0FF;
    // Digit carry is the same no-borrow test on the low nibble alone
    assign dec_low    = {1'b0, REG_RDATA[3:0]} + 5'h0F;
    assign dec_result = dec_full[7:0];
    // Only 0x80 minus one crosses from the most negative value to a positive one
    assign dec_ovf    = (REG_RDATA == 8'h80);
    assign dec_zero   = (dec_result == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Skip sequencer: a taken less-than compare opens one idle slot, and a
    // second one when the fetch side flags the discarded word as two words.
    // The flag is looked at in the first idle slot only, so it may change later.
    always_comb begin
        next_state = exec_pkg::ST_EXEC;
        unique case (state)
            exec_pkg::ST_EXEC: begin
                if (is_compare && (REG_RDATA < WORKING)) begin
                    next_state = exec_pkg::ST_IDLE1;
                end
            end
            exec_pkg::ST_IDLE1: begin
                if (NEXT_IS_TWO_WORD) begin
                    next_state = exec_pkg::ST_IDLE2;
                end
            end
            exec_pkg::ST_IDLE2: next_state = exec_pkg::ST_EXEC;
            default:            next_state = exec_pkg::ST_EXEC;
        endcase
    end

    // With no word offered the sequencer simply waits in the execute state;
    // idle slots run down whether or not the fetch side offers a word
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= exec_pkg::ST_EXEC;
        end else if (INSTR_VALID || state != exec_pkg::ST_EXEC) begin
            state <= next_state;
        end
    end

    // Registered mirror of the idle states, so the fetch side sees it from a flop
    // in the same cycle as the idle slot itself
    always_ff @(posedge CLK) begin
        if (RESET) begin
            DISCARD <= 1'b0;
        end else begin
            DISCARD <= (next_state != exec_pkg::ST_EXEC) && (INSTR_VALID || state != exec_pkg::ST_EXEC);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only decimal adjust and a decrement aimed at the working register touch it;
    // a compare reads it but never writes it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            WORKING <= exec_pkg::RESET_WORKING;
        end else if (is_adjust) begin
            WORKING <= {high_adj[3:0], low_adj[3:0]};
        end else if (is_decrement && !to_register(INSTR)) begin
            WORKING <= dec_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decimal adjust only ever sets carry. Clearing it there would lose the
    // carry of the addition that came before, which a multi-byte BCD sum needs.
    // Digit carry stays as it was, so a second adjust sees the same digit carry input.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            STATUS <= exec_pkg::RESET_STATUS;
        end else if (is_adjust) begin
            if (high_adj[4] || low_wrap) begin
                STATUS.carry <= 1'b1;
            end
        end else if (is_decrement) begin
            STATUS.carry  <= dec_full[8];
            STATUS.dcarry <= dec_low[4];
            STATUS.neg    <= dec_result[7];
            STATUS.zero   <= dec_zero;
            STATUS.ovf    <= dec_ovf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bank select is loaded from outside; a load in the same cycle as a banked
    // access takes effect only for the next word
    always_ff @(posedge CLK) begin
        if (RESET) begin
            BANK <= exec_pkg::RESET_BANK;
        end else if (BANK_LOAD) begin
            BANK <= BANK_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address and data follow every cycle and only the strobe qualifies them.
    // Leaving them free keeps the write port a plain register with no enable;
    // the memory side must look at them only while the strobe is high.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            MEM_WRITE <= '0;
        end else begin
            MEM_WRITE.addr  <= eff_addr;
            MEM_WRITE.data  <= dec_result;
            MEM_WRITE.write <= is_decrement && to_register(INSTR);
        end
    end

endmodule

// ---- testbench/exec_properties.sv ----
module exec_properties (
    input wire logic        CLK, RESET, INSTR_VALID, NEXT_IS_TWO_WORD, DISCARD,
    input wire logic [15:0] INSTR,
    input wire logic [7:0]  REG_RDATA, WORKING,
    input wire logic [3:0]  BANK,
    input exec_pkg::status_t  STATUS,
    input exec_pkg::mem_req_t MEM_WRITE);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Idle slots never count as taken words
    wire tk = INSTR_VALID & ~DISCARD;
    wire dec = tk & (INSTR[15:10] == exec_pkg::OPC_DECREMENT);
    wire adj = tk & (INSTR == exec_pkg::OPC_DECIMAL_ADJUST);
    wire [7:0] dr = REG_RDATA - 8'h01;
    ////////////////////////////////////////////////////////////////////////////////
    skip_a: assert property (tk && INSTR[15:9] == exec_pkg::OPC_COMPARE_LESS
        |=> DISCARD == ($past(REG_RDATA) < $past(WORKING))) else $error("skip");
    idle_a: assert property (DISCARD && !$past(DISCARD) |=> DISCARD == $past(NEXT_IS_TWO_WORD))
        else $error("idle");
    low_a: assert property (adj && WORKING[3:0] < 4'hA && !STATUS.dcarry
        |=> WORKING[3:0] == $past(WORKING[3:0])) else $error("low nibble");
    adj_a: assert property (adj |=> STATUS[4:1] == $past(STATUS[4:1]) && !MEM_WRITE.write)
        else $error("adjust");
    dec_w_a: assert property (dec && !INSTR[9] |=> WORKING == $past(dr) && !MEM_WRITE.write)
        else $error("dec w");
    dec_f_a: assert property (dec && INSTR[9] |=> MEM_WRITE.write && MEM_WRITE.data == $past(dr))
        else $error("dec f");
    flags_a: assert property (dec |=> STATUS == $past({dr[7], REG_RDATA == 8'h80, dr == 8'h00,
        REG_RDATA[3:0] != 4'h0, REG_RDATA != 8'h00})) else $error("flags");
    bank_a: assert property (dec && INSTR[9] |=> MEM_WRITE.addr ==
        $past(INSTR[8] ? {BANK, INSTR[7:0]} : {{4{INSTR[7]}}, INSTR[7:0]})) else $error("bank");
    cover property (DISCARD [*2]);
    cover property (adj);
    cover property (MEM_WRITE.write);
endmodule
bind bcd_adjust_decrement_skip_exec exec_properties exec_properties_i (.*);

// ---- testbench/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        CLK = 1'h0, RESET = 1'h1, INSTR_VALID = 1'h0, NEXT_IS_TWO_WORD = 1'h0, BANK_LOAD = 1'h0;
    logic        DISCARD, sk, c = 1'h0, dc = 1'h0;
    logic [15:0] INSTR = 16'h0000, op;
    logic [7:0]  REG_RDATA = 8'h00, WORKING, w = 8'h00;
    logic [8:0]  v;
    logic [4:0]  r5;
    logic [3:0]  bk = 4'h0;
    logic [3:0]  BANK_VALUE = 4'h0, BANK;
    logic [24:0] corner [8] = '{{16'h0410, 8'hA6, 1'h0}, {16'h0007, 8'h00, 1'h0}, {16'h0410, 8'hCF, 1'h0},
        {16'h0007, 8'h00, 1'h0}, {16'h0790, 8'h00, 1'h0}, {16'h0680, 8'h80, 1'h0}, {16'h6100, 8'h33, 1'h1},
        {16'h6000, 8'h34, 1'h0}};
    exec_pkg::status_t  STATUS;
    exec_pkg::mem_req_t MEM_WRITE;
    int num_errors = 0, comparisons = 0, seed = 75923, cyc = 0, k;
    bcd_adjust_decrement_skip_exec bcd_adjust_decrement_skip_exec_i (.*);
    initial forever #12.5 CLK = ~CLK;
    always @(posedge CLK) if (++cyc == 3000) begin num_errors++; stop_test(); end
    task automatic check(input string what, input logic [7:0] seen, want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic run(input logic [15:0] o, input logic [7:0] rd, input logic two);
        sk = o[15:9] == exec_pkg::OPC_COMPARE_LESS && rd < w;
        @(posedge CLK);
        {INSTR, REG_RDATA, INSTR_VALID, NEXT_IS_TWO_WORD} <= {o, rd, 1'h1, two};
        r5 = 5'($random(seed));
        {BANK_LOAD, BANK_VALUE} <= r5;
        if (r5[4]) bk = r5[3:0];
        if (o[15:10] == exec_pkg::OPC_DECREMENT) {c, dc} = {rd != 8'h00, rd[3:0] != 4'h0};
        if (o[15:9] == {exec_pkg::OPC_DECREMENT, 1'h0}) w = rd - 8'h01;
        if (o == exec_pkg::OPC_DECIMAL_ADJUST) begin
            v = w + ((w[3:0] > 4'h9 || dc) ? 9'h006 : 9'h000);
            v = v + ((v[7:4] > 4'h9 || c || v[8]) ? 9'h060 : 9'h000);
            {c, w} = {c | v[8], v[7:0]};
        end
        @(posedge CLK);
        // A decrement of zero offered in idle slots would corrupt the working value if taken
        {INSTR, INSTR_VALID} <= {16'h0400, sk};
        #1 check("working", WORKING, w);
        check("flags", 8'({STATUS.carry, DISCARD, MEM_WRITE.write}),
            8'({c, sk, o[15:9] == {exec_pkg::OPC_DECREMENT, 1'h1}}));
        check("bank", 8'(BANK), 8'(bk));
        if (sk) begin
            repeat (two ? 2 : 1) @(posedge CLK);
            INSTR_VALID <= 1'h0;
            #1 check("idle end", 8'(DISCARD), 8'h00);
        end
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RESET <= 1'h0;
        foreach (corner[i]) run(corner[i][24:9], corner[i][8:1], corner[i][0]);
        $display("corner test done");
        repeat (400) begin
            k = $random(seed);
            op = k[1] ? ((k[0] || w > 8'hF9) ? {exec_pkg::OPC_COMPARE_LESS, k[10:2]} : exec_pkg::OPC_DECIMAL_ADJUST)
                : {exec_pkg::OPC_DECREMENT, k[11:2]};
            run(op, k[19:12], k[20]);
        end
        $display("random test done");
        stop_test();
    end
endmodule
